// [sfc_bus_cycle.sv]
// sfc_bus_cycle: one asynchronous flash bus read or write cycle
// assumes the flash pins are sampled a strobe-width after assertion
`timescale 1ns/100ps
module sfc_bus_cycle import sfc_pkg::*; (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic write_i,
  input wire logic [SFC_ADDR_W-1:0] addr_i,
  input wire logic [SFC_DATA_W-1:0] wdata_i,
  input wire logic [SFC_DATA_W-1:0] dq_sync_i,
  output logic done_o,
  output logic [SFC_DATA_W-1:0] rdata_o,
  output logic [SFC_ADDR_W-1:0] addr_o,
  output logic [SFC_DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  output logic ce_n_o,
  output logic we_n_o,
  output logic oe_n_o
);
  sfc_bus_state_t state;
  logic is_write;
  logic [SFC_CNT_W-1:0] cnt;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state <= SFC_BUS_IDLE;
      cnt <= '0;
      is_write <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      unique case (state)
        SFC_BUS_IDLE: begin
          if (start_i) begin
            is_write <= write_i;
            state <= SFC_BUS_SETUP;
          end
        end
        SFC_BUS_SETUP: begin
          cnt <= SFC_CNT_W'(SFC_STROBE_CYC);
          state <= SFC_BUS_STROBE;
        end
        SFC_BUS_STROBE: begin
          if (cnt == '0) state <= SFC_BUS_HOLD;
          else cnt <= cnt - 1'b1;
        end
        SFC_BUS_HOLD: begin
          done_o <= 1'b1;
          state <= SFC_BUS_IDLE;
        end
        default: state <= SFC_BUS_IDLE;
      endcase
    end
  end

  // pins: the data bus is driven while we_n is low, setting up, or in the hold cycle after we_n rises, never with oe_n low
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      addr_o <= '0;
      dq_o <= '0;
      dq_oe_o <= 1'b0;
      ce_n_o <= 1'b1;
      we_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      rdata_o <= '0;
    end else begin
      if (state == SFC_BUS_IDLE && start_i) begin
        addr_o <= addr_i;
        dq_o <= wdata_i;
        dq_oe_o <= write_i;
        ce_n_o <= 1'b0;
      end
      if (state == SFC_BUS_SETUP) begin
        we_n_o <= ~is_write;
        oe_n_o <= is_write;
      end
      if (state == SFC_BUS_STROBE && cnt == '0) begin
        if (!is_write) rdata_o <= dq_sync_i;
        we_n_o <= 1'b1;
        oe_n_o <= 1'b1;
      end
      if (state == SFC_BUS_HOLD) begin
        dq_oe_o <= 1'b0;
        ce_n_o <= 1'b1;
      end
    end
  end
endmodule : sfc_bus_cycle

// [sfc_ctrl.sv]
// sfc_ctrl: host controller for a sector-erasable byte flash
// Functional notes
// - separate active-low select, write, output strobes
// - commands are plain bus write cycles
// - host polls poll and toggle bits
// - host may suspend and resume sector erase
// assumes software orders through a plain register port; dq pins are async
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/100ps
module sfc_ctrl import sfc_pkg::*; (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic irq_o,
  output logic [SFC_ADDR_W-1:0] fl_addr_o,
  input wire logic [SFC_DATA_W-1:0] fl_dq_i,
  output logic [SFC_DATA_W-1:0] fl_dq_o,
  output logic fl_dq_oe_o,
  output logic fl_ce_n_o,
  output logic fl_we_n_o,
  output logic fl_oe_n_o
);
  sfc_state_t state;
  logic [SFC_DATA_W-1:0] dq_s1, dq_s2, dq_s3, dq_sync;
  logic [SFC_ADDR_W-1:0] op_addr;
  logic [SFC_DATA_W-1:0] op_data;
  logic [SFC_SECTORS-1:0] sect_mask;
  logic [2:0] op_code;
  logic [2:0] step;
  logic [2:0] nsteps;
  logic busy, suspended, refused, timeout;
  logic [SFC_IRQ_W-1:0] irq_stat, irq_mask;
  logic [SFC_DATA_W-1:0] read_byte, last_poll;
  logic poll_primed, susp_req;
  logic cyc_start, cyc_write, cyc_done;
  logic [SFC_ADDR_W-1:0] cyc_addr;
  logic [SFC_DATA_W-1:0] cyc_wdata, cyc_rdata;
  logic ev_done, ev_ref;
  logic ctrl_wr;

  // three-stage sampling of the async data lines; change accepted when stages 2 and 3 agree
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      dq_s1 <= '0;
      dq_s2 <= '0;
      dq_s3 <= '0;
      dq_sync <= '0;
    end else begin
      dq_s1 <= fl_dq_i;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
      for (int i = 0; i < SFC_DATA_W; i++) begin
        if (dq_s2[i] == dq_s3[i]) dq_sync[i] <= dq_s3[i];
      end
    end
  end

  assign ctrl_wr = reg_wr_i && reg_addr_i == SFC_REG_CTRL;

  // command sequence table: unlock, unlock, command, then for erase a second unlock and target
  always_comb begin
    cyc_addr = SFC_UNLOCK_A1;
    cyc_wdata = SFC_UNLOCK_D1;
    cyc_write = 1'b1;
    unique case (step)
      3'd0: begin
        cyc_addr = SFC_UNLOCK_A1;
        cyc_wdata = SFC_UNLOCK_D1;
      end
      3'd1: begin
        cyc_addr = SFC_UNLOCK_A2;
        cyc_wdata = SFC_UNLOCK_D2;
      end
      3'd2: begin
        cyc_addr = SFC_UNLOCK_A1;
        cyc_wdata = (op_code == SFC_OP_PROG) ? SFC_CMD_PROG : SFC_CMD_ERASE;
      end
      3'd3: begin
        cyc_addr = (op_code == SFC_OP_PROG) ? op_addr : SFC_UNLOCK_A1;
        cyc_wdata = (op_code == SFC_OP_PROG) ? op_data : SFC_UNLOCK_D1;
      end
      3'd4: begin
        cyc_addr = SFC_UNLOCK_A2;
        cyc_wdata = SFC_UNLOCK_D2;
      end
      default: begin
        cyc_addr = (op_code == SFC_OP_CHIP) ? SFC_UNLOCK_A1 : op_addr;
        cyc_wdata = (op_code == SFC_OP_CHIP) ? SFC_CMD_CHIP : SFC_CMD_SECT;
      end
    endcase
    if (state == SFC_POLL || state == SFC_RDONE) begin
      cyc_write = 1'b0;
      cyc_addr = op_addr;
    end
    if (op_code == SFC_OP_SUSP || op_code == SFC_OP_RESUME || op_code == SFC_OP_RESET) begin
      cyc_addr = op_addr;
      cyc_wdata = (op_code == SFC_OP_SUSP) ? SFC_CMD_SUSP :
                  (op_code == SFC_OP_RESUME) ? SFC_CMD_RESUME : SFC_CMD_RESET;
    end
    if (op_code == SFC_OP_READ) cyc_write = 1'b0;
  end

  // main sequencer
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state <= SFC_IDLE;
      step <= '0;
      nsteps <= '0;
      op_code <= SFC_OP_READ;
      op_addr <= '0;
      op_data <= SFC_ERASED_BYTE;
      busy <= 1'b0;
      suspended <= 1'b0;
      refused <= 1'b0;
      timeout <= 1'b0;
      cyc_start <= 1'b0;
      read_byte <= SFC_ERASED_BYTE;
      last_poll <= '0;
      poll_primed <= 1'b0;
      susp_req <= 1'b0;
      ev_done <= 1'b0;
      ev_ref <= 1'b0;
    end else begin
      cyc_start <= 1'b0;
      ev_done <= 1'b0;
      ev_ref <= 1'b0;
      if (reg_wr_i && reg_addr_i == SFC_REG_ADDR) op_addr <= reg_wdata_i[SFC_ADDR_W-1:0];
      if (reg_wr_i && reg_addr_i == SFC_REG_DATA) op_data <= reg_wdata_i[SFC_DATA_W-1:0];
      unique case (state)
        SFC_IDLE: begin
          susp_req <= 1'b0;
          if (ctrl_wr && reg_wdata_i[2:0] != 3'h0) begin
            op_code <= reg_wdata_i[2:0];
            step <= '0;
            refused <= 1'b0;
            timeout <= 1'b0;
            cyc_start <= 1'b1;
            state <= SFC_SEQ;
            busy <= 1'b1;
            // protected or erasing sector: refuse locally
            if ((reg_wdata_i[2:0] == SFC_OP_PROG || reg_wdata_i[2:0] == SFC_OP_SECT) &&
                sect_mask[op_addr[SFC_ADDR_W-1 -: 3]]) begin
              cyc_start <= 1'b0;
              state <= SFC_IDLE;
              busy <= 1'b0;
              refused <= 1'b1;
              ev_ref <= 1'b1;
            end
            unique case (reg_wdata_i[2:0])
              SFC_OP_PROG: nsteps <= 3'd3;
              SFC_OP_SECT, SFC_OP_CHIP: nsteps <= 3'd5;
              default: nsteps <= 3'd0;
            endcase
            if (reg_wdata_i[2:0] == SFC_OP_READ) state <= SFC_RDONE;
          end
        end
        SFC_SEQ: begin
          if (cyc_done) begin
            if (step == nsteps) begin
              if (op_code == SFC_OP_SUSP) suspended <= 1'b1;
              if (op_code == SFC_OP_RESUME) suspended <= 1'b0;
              if (op_code == SFC_OP_PROG || op_code == SFC_OP_SECT || op_code == SFC_OP_CHIP ||
                  op_code == SFC_OP_RESUME) begin
                state <= SFC_POLL;
                poll_primed <= 1'b0;
              end else begin
                state <= SFC_IDLE;
                busy <= 1'b0;
                ev_done <= 1'b1;
              end
            end else step <= step + 1'b1;
            cyc_start <= (step != nsteps) || op_code == SFC_OP_PROG || op_code == SFC_OP_SECT ||
                         op_code == SFC_OP_CHIP || op_code == SFC_OP_RESUME;
          end
        end
        SFC_POLL: begin
          // toggle bits stop toggling once the embedded algorithm is over
          if (ctrl_wr && reg_wdata_i[2:0] == SFC_OP_SUSP &&
              (op_code == SFC_OP_SECT || op_code == SFC_OP_RESUME)) susp_req <= 1'b1;
          if (cyc_done) begin
            last_poll <= cyc_rdata;
            read_byte <= cyc_rdata;
            poll_primed <= 1'b1;
            // first read only primes the history: a stale byte could look settled
            if (poll_primed && cyc_rdata[SFC_TOGGLE_BIT] == last_poll[SFC_TOGGLE_BIT] &&
                cyc_rdata[SFC_TOGGLE2_BIT] == last_poll[SFC_TOGGLE2_BIT]) begin
              state <= SFC_IDLE;
              busy <= 1'b0;
              ev_done <= 1'b1;
              // for a program the poll bit must match the written data, otherwise it did not take
              if (op_code == SFC_OP_PROG &&
                  cyc_rdata[SFC_POLL_BIT] != op_data[SFC_POLL_BIT]) begin
                refused <= 1'b1;
                ev_ref <= 1'b1;
              end
            end else if (susp_req) begin
              // suspend goes out between two poll reads, when the bus is free
              op_code <= SFC_OP_SUSP;
              step <= '0;
              nsteps <= '0;
              susp_req <= 1'b0;
              cyc_start <= 1'b1;
              state <= SFC_SEQ;
            end else cyc_start <= 1'b1;
          end
        end
        SFC_RDONE: begin
          if (cyc_done) begin
            read_byte <= cyc_rdata;
            state <= SFC_IDLE;
            busy <= 1'b0;
            ev_done <= 1'b1;
          end
        end
        default: state <= SFC_IDLE;
      endcase
    end
  end

  // protection and erasing-sector mask kept by software
  always_ff @(posedge core_clk_i) begin
    if (rst_i) sect_mask <= '0;
    else if (reg_wr_i && reg_addr_i == SFC_REG_SMASK) sect_mask <= reg_wdata_i[SFC_SECTORS-1:0];
  end

  // sticky events, set wins over write-one-to-clear
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_stat <= '0;
      irq_mask <= '0;
      irq_o <= 1'b0;
    end else begin
      if (reg_wr_i && reg_addr_i == SFC_REG_MASK) irq_mask <= reg_wdata_i[SFC_IRQ_W-1:0];
      irq_stat <= (irq_stat & ~((reg_wr_i && reg_addr_i == SFC_REG_IRQ) ? reg_wdata_i[SFC_IRQ_W-1:0] : '0))
                  | {ev_ref, ev_done};
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) reg_rdata_o <= '0;
    else if (reg_rd_i) begin
      unique case (reg_addr_i)
        SFC_REG_CTRL: reg_rdata_o <= {29'h0, op_code};
        SFC_REG_ADDR: reg_rdata_o <= {13'h0, op_addr};
        SFC_REG_DATA: reg_rdata_o <= {24'h0, op_data};
        SFC_REG_STAT: reg_rdata_o <= {28'h0, timeout, refused, suspended, busy};
        SFC_REG_IRQ: reg_rdata_o <= {30'h0, irq_stat};
        SFC_REG_MASK: reg_rdata_o <= {30'h0, irq_mask};
        SFC_REG_SMASK: reg_rdata_o <= {24'h0, sect_mask};
        SFC_REG_RDATA: reg_rdata_o <= {24'h0, read_byte};
        default: reg_rdata_o <= '0;
      endcase
    end else reg_rdata_o <= '0;
  end

  sfc_bus_cycle u_cycle (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .start_i(cyc_start),
    .write_i(cyc_write),
    .addr_i(cyc_addr),
    .wdata_i(cyc_wdata),
    .dq_sync_i(dq_sync),
    .done_o(cyc_done),
    .rdata_o(cyc_rdata),
    .addr_o(fl_addr_o),
    .dq_o(fl_dq_o),
    .dq_oe_o(fl_dq_oe_o),
    .ce_n_o(fl_ce_n_o),
    .we_n_o(fl_we_n_o),
    .oe_n_o(fl_oe_n_o)
  );
endmodule : sfc_ctrl

// [sfc_ctrl_checker.sv]
// sfc_ctrl_checker: port-level checks on the flash pins and register port of sfc_ctrl
// assumes one clock domain and the synchronous active-high reset of the controller
`timescale 1ns/100ps
module sfc_ctrl_checker import sfc_pkg::*; (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic irq_o,
  input wire logic [SFC_ADDR_W-1:0] fl_addr_o,
  input wire logic [SFC_DATA_W-1:0] fl_dq_i,
  input wire logic [SFC_DATA_W-1:0] fl_dq_o,
  input wire logic fl_dq_oe_o,
  input wire logic fl_ce_n_o,
  input wire logic fl_we_n_o,
  input wire logic fl_oe_n_o
);
  logic [7:0] scnt;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // counts strobe-low cycles, too long for a repetition
  always_ff @(posedge core_clk_i) begin
    if (rst_i || (fl_we_n_o && fl_oe_n_o)) scnt <= 8'h00;
    else scnt <= scnt + 8'h01;
  end
  a_no_contention: assert property (fl_dq_oe_o |-> fl_oe_n_o)
    else $error("data lines driven during a read strobe");
  a_strobe_excl: assert property (!(!fl_we_n_o && !fl_oe_n_o))
    else $error("write and read strobes low together");
  a_strobe_select: assert property (!(fl_we_n_o && fl_oe_n_o) |-> !fl_ce_n_o)
    else $error("strobe without chip select");
  a_strobe_width: assert property ($rose(fl_we_n_o) || $rose(fl_oe_n_o) |-> scnt == SFC_STROBE_CYC + 1)
    else $error("strobe width wrong");
  a_write_drives: assert property (!fl_we_n_o |-> fl_dq_oe_o && $stable(fl_dq_o))
    else $error("write data not driven steady");
  a_addr_held: assert property (!fl_we_n_o || !fl_oe_n_o |-> $stable(fl_addr_o))
    else $error("address moved under a strobe");
  a_ce_release: assert property ($rose(fl_we_n_o) || $rose(fl_oe_n_o) |-> ##[1:4] fl_ce_n_o)
    else $error("select not released after a cycle");
  a_reset_idle: assert property ($past(rst_i) |-> fl_ce_n_o && fl_we_n_o && fl_oe_n_o && !fl_dq_oe_o && !irq_o)
    else $error("pins not idle after reset");
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside its cycle");
endmodule : sfc_ctrl_checker
bind sfc_ctrl sfc_ctrl_checker chk_i (.core_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
  .reg_rdata_o, .irq_o, .fl_addr_o, .fl_dq_i, .fl_dq_o, .fl_dq_oe_o, .fl_ce_n_o, .fl_we_n_o, .fl_oe_n_o);

// [sfc_flash_model.sv]
// sfc_flash_model: behavioural byte flash with command sequencer and status bits
// assumes the controller pins; it also resolves the shared data lines
`timescale 1ns/100ps
module sfc_flash_model import sfc_pkg::*; #(
  parameter logic [7:0] PROT = 8'h08,
  parameter int PROG_N = 2,
  parameter int ERASE_N = 30
) (
  input wire logic [SFC_ADDR_W-1:0] addr_i,
  input wire logic [SFC_DATA_W-1:0] ctl_dq_i,
  input wire logic ctl_oe_i,
  input wire logic ce_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic lowv_i,
  output logic [SFC_DATA_W-1:0] bus_o
);
  logic [7:0] mem [logic [18:0]];
  logic [7:0] drv, poll, last = 8'h00;
  logic tog = 1'b0, ers = 1'b0, susp = 1'b0;
  logic m_oe;
  int step = 0, busy = 0, held = 0;
  function automatic logic [7:0] rd(logic [18:0] a);
    return mem.exists(a) ? mem[a] : SFC_ERASED_BYTE;
  endfunction : rd
  assign m_oe = !ce_n_i && !oe_n_i;
  // released lines show the inverse of the last value so a stale sample fails
  assign bus_o = ctl_oe_i ? (m_oe ? 8'hxx : ctl_dq_i) : (m_oe ? drv : ~last);
  always @(bus_o) if (ctl_oe_i || m_oe) last = bus_o;
  always @(negedge oe_n_i) drv = busy > 0 ? {poll[7], tog, 3'h0, tog, 2'h0} : rd(addr_i);
  always @(posedge oe_n_i) if (busy > 0 && !ce_n_i) begin
    busy--;
    tog = ~tog;
  end
  always @(posedge we_n_i) if (!ce_n_i && !lowv_i) begin
    if (ctl_dq_i == SFC_CMD_RESET) step = 0;
    else if (busy > 0 && ers && ctl_dq_i == SFC_CMD_SUSP) begin
      held = busy;
      busy = 0;
      susp = 1'b1;
    end else if (susp && step == 0 && ctl_dq_i == SFC_CMD_RESUME) begin
      busy = held;
      poll = 8'h00;
      ers = 1'b1;
      susp = 1'b0;
    end else case (step)
      0, 4: step = ctl_dq_i == SFC_UNLOCK_D1 && addr_i == SFC_UNLOCK_A1 ? step + 1 : 0;
      1, 5: step = ctl_dq_i == SFC_UNLOCK_D2 && addr_i == SFC_UNLOCK_A2 ? step + 1 : 0;
      2: step = ctl_dq_i == SFC_CMD_PROG ? 3 : ctl_dq_i == SFC_CMD_ERASE ? 4 : 0;
      3: begin
        if (!PROT[addr_i[18:16]]) mem[addr_i] = rd(addr_i) & ctl_dq_i;
        poll = ~ctl_dq_i;
        ers = 1'b0;
        busy = PROG_N;
        step = 0;
      end
      6: begin
        foreach (mem[a]) begin
          if (!PROT[a[18:16]] && (ctl_dq_i == SFC_CMD_CHIP || a[18:16] == addr_i[18:16])) mem[a] = SFC_ERASED_BYTE;
        end
        poll = 8'h00;
        ers = 1'b1;
        busy = ERASE_N;
        step = 0;
      end
      default: step = 0;
    endcase
  end
endmodule : sfc_flash_model

// [sfc_pkg.sv]
// sfc_pkg: constants for the sector flash command controller
// assumes a byte-wide flash with eight 64 Kbyte sectors on an async parallel bus
package sfc_pkg;
  localparam int SFC_ADDR_W = 19;
  localparam int SFC_DATA_W = 8;
  localparam int SFC_SECTORS = 8;
  localparam int SFC_SECTOR_KB = 64;
  localparam int SFC_SECTOR_BYTES = SFC_SECTOR_KB * 1024;
  localparam logic [7:0] SFC_ERASED_BYTE = 8'hff;
  localparam int SFC_POLL_BIT = 7;
  localparam int SFC_TOGGLE_BIT = 6;
  localparam int SFC_TOGGLE2_BIT = 2;
  // unlock addresses and command codes: not given, plain defaults
  localparam logic [18:0] SFC_UNLOCK_A1 = 19'h00555;
  localparam logic [18:0] SFC_UNLOCK_A2 = 19'h002aa;
  localparam logic [7:0] SFC_UNLOCK_D1 = 8'haa;
  localparam logic [7:0] SFC_UNLOCK_D2 = 8'h55;
  localparam logic [7:0] SFC_CMD_PROG = 8'ha0;
  localparam logic [7:0] SFC_CMD_ERASE = 8'h80;
  localparam logic [7:0] SFC_CMD_CHIP = 8'h10;
  localparam logic [7:0] SFC_CMD_SECT = 8'h30;
  localparam logic [7:0] SFC_CMD_SUSP = 8'hb0;
  localparam logic [7:0] SFC_CMD_RESUME = 8'h30;
  localparam logic [7:0] SFC_CMD_RESET = 8'hf0;
  // bus strobe timing
  localparam int SFC_CLK_NS = 10;
  localparam int SFC_STROBE_NS = 100;
  localparam int SFC_STROBE_CYC = (SFC_STROBE_NS + SFC_CLK_NS - 1) / SFC_CLK_NS;
  localparam int SFC_CNT_W = 4;
  // register map (word index = address)
  localparam logic [3:0] SFC_REG_CTRL = 4'h0;
  localparam logic [3:0] SFC_REG_ADDR = 4'h1;
  localparam logic [3:0] SFC_REG_DATA = 4'h2;
  localparam logic [3:0] SFC_REG_STAT = 4'h3;
  localparam logic [3:0] SFC_REG_IRQ = 4'h4;
  localparam logic [3:0] SFC_REG_MASK = 4'h5;
  localparam logic [3:0] SFC_REG_SMASK = 4'h6;
  localparam logic [3:0] SFC_REG_RDATA = 4'h7;
  // ctrl opcodes (written to CTRL bits 2:0)
  localparam logic [2:0] SFC_OP_READ = 3'h1;
  localparam logic [2:0] SFC_OP_PROG = 3'h2;
  localparam logic [2:0] SFC_OP_SECT = 3'h3;
  localparam logic [2:0] SFC_OP_CHIP = 3'h4;
  localparam logic [2:0] SFC_OP_SUSP = 3'h5;
  localparam logic [2:0] SFC_OP_RESUME = 3'h6;
  localparam logic [2:0] SFC_OP_RESET = 3'h7;
  // irq bits
  localparam int SFC_IRQ_DONE = 0;
  localparam int SFC_IRQ_REFUSED = 1;
  localparam int SFC_IRQ_W = 2;
  typedef enum logic [2:0] {SFC_BUS_IDLE, SFC_BUS_SETUP, SFC_BUS_STROBE, SFC_BUS_HOLD} sfc_bus_state_t;
  typedef enum logic [2:0] {SFC_IDLE, SFC_SEQ, SFC_POLL, SFC_RDONE} sfc_state_t;
endpackage : sfc_pkg

// [tb_sfc_ctrl.sv]
// tb_sfc_ctrl: register-level tests of sfc_ctrl against the flash model
// assumes sector 3 of the model is protected
`timescale 1ns/100ps
module tb_sfc_ctrl import sfc_pkg::*; ;
  logic core_clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, lowv = 0;
  logic [3:0] reg_addr_i = 0;
  logic [31:0] reg_wdata_i = 0, reg_rdata_o, v;
  logic irq_o, dq_oe, ce_n, we_n, oe_n;
  logic [SFC_ADDR_W-1:0] fa;
  logic [7:0] dq_o, dq_w;
  int miscompares = 0, checks_done = 0;
  always #5 core_clk_i = ~core_clk_i;
  sfc_ctrl dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .fl_addr_o(fa),
    .fl_dq_i(dq_w), .fl_dq_o(dq_o), .fl_dq_oe_o(dq_oe), .fl_ce_n_o(ce_n), .fl_we_n_o(we_n), .fl_oe_n_o(oe_n));
  sfc_flash_model flash (.addr_i(fa), .ctl_dq_i(dq_o), .ctl_oe_i(dq_oe), .ce_n_i(ce_n), .we_n_i(we_n),
    .oe_n_i(oe_n), .lowv_i(lowv), .bus_o(dq_w));
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rdv(logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : rdv
  task automatic rd(logic [3:0] a, logic [31:0] e, string n);
    rdv(a, v);
    chk(n, v, e);
  endtask : rd
  task automatic bit_is(logic [3:0] a, int b, logic e, string n);
    rdv(a, v);
    chk(n, {31'h0, v[b]}, {31'h0, e});
  endtask : bit_is
  task automatic wait_idle;
    int i;
    for (i = 0; i < 2000; i++) begin
      rdv(SFC_REG_STAT, v);
      if (v[0] === 1'b0) break;
    end
    if (i == 2000) begin
      miscompares++;
      test_done();
    end
  endtask : wait_idle
  task automatic op(logic [2:0] o, logic [18:0] a, logic [7:0] d);
    wr(SFC_REG_ADDR, 32'(a));
    wr(SFC_REG_DATA, 32'(d));
    wr(SFC_REG_CTRL, 32'(o));
    wait_idle();
  endtask : op
  task automatic frd(logic [18:0] a, logic [7:0] e);
    op(SFC_OP_READ, a, 8'h00);
    rd(SFC_REG_RDATA, 32'(e), "flash byte");
  endtask : frd
  task automatic irq_is(logic e);
    repeat (2) @(posedge core_clk_i);
    #1 chk("irq_o", {31'h0, irq_o}, {31'h0, e});
  endtask : irq_is
  initial begin
    repeat (20) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(SFC_REG_STAT, 32'h0, "stat");
    rd(SFC_REG_IRQ, 32'h0, "irq");
    rd(4'h8, 32'h0, "unmapped");
    frd(19'h12345, 8'hff);
    op(SFC_OP_PROG, 19'h12345, 8'ha5);
    rd(SFC_REG_IRQ, 32'h1, "irq done");
    irq_is(1'b0);
    frd(19'h12345, 8'ha5);
    op(SFC_OP_PROG, 19'h12345, 8'h0f);
    frd(19'h12345, 8'h05);
    wr(SFC_REG_MASK, 32'h1);
    irq_is(1'b1);
    wr(SFC_REG_IRQ, 32'h3);
    irq_is(1'b0);
    op(SFC_OP_PROG, 19'h20010, 8'h3c);
    op(SFC_OP_SECT, 19'h10000, 8'h00);
    frd(19'h12345, 8'hff);
    frd(19'h20010, 8'h3c);
    wr(SFC_REG_IRQ, 32'h3);
    op(SFC_OP_PROG, 19'h30000, 8'h00);
    bit_is(SFC_REG_IRQ, 1, 1'b1, "refused");
    frd(19'h30000, 8'hff);
    wr(SFC_REG_IRQ, 32'h3);
    wr(SFC_REG_SMASK, 32'h10);
    op(SFC_OP_PROG, 19'h40000, 8'h00);
    bit_is(SFC_REG_IRQ, 1, 1'b1, "avoided");
    wr(SFC_REG_SMASK, 32'h0);
    frd(19'h40000, 8'hff);
    op(SFC_OP_PROG, 19'h50000, 8'h00);
    wr(SFC_REG_ADDR, 32'h50000);
    wr(SFC_REG_CTRL, 32'(SFC_OP_SECT));
    repeat (200) @(posedge core_clk_i);
    wr(SFC_REG_CTRL, 32'(SFC_OP_SUSP));
    wait_idle();
    bit_is(SFC_REG_STAT, 1, 1'b1, "suspended");
    op(SFC_OP_PROG, 19'h60000, 8'h5a);
    frd(19'h60000, 8'h5a);
    op(SFC_OP_RESUME, 19'h50000, 8'h00);
    bit_is(SFC_REG_STAT, 1, 1'b0, "resumed");
    frd(19'h50000, 8'hff);
    lowv <= 1'b1;
    op(SFC_OP_PROG, 19'h70000, 8'h12);
    lowv <= 1'b0;
    frd(19'h70000, 8'hff);
    op(SFC_OP_CHIP, 19'h00000, 8'h00);
    frd(19'h60000, 8'hff);
    op(SFC_OP_RESET, 19'h00000, 8'h00);
    bit_is(SFC_REG_STAT, 0, 1'b0, "idle");
    test_done();
  end
endmodule : tb_sfc_ctrl
